// *** design/jtsc_pkg.sv ***
package jtsc_pkg;
   // TAP states, one-hot codes
   typedef enum logic [15:0] {
      ST_RESET = 16'h0001,
      ST_IDLE = 16'h0002,
      ST_SEL_DR = 16'h0004,
      ST_CAP_DR = 16'h0008,
      ST_SH_DR = 16'h0010,
      ST_EX1_DR = 16'h0020,
      ST_PAU_DR = 16'h0040,
      ST_EX2_DR = 16'h0080,
      ST_UPD_DR = 16'h0100,
      ST_SEL_IR = 16'h0200,
      ST_CAP_IR = 16'h0400,
      ST_SH_IR = 16'h0800,
      ST_EX1_IR = 16'h1000,
      ST_PAU_IR = 16'h2000,
      ST_EX2_IR = 16'h4000,
      ST_UPD_IR = 16'h8000
   } jtsc_state_e;

   localparam int IR_W = 4;
   localparam int ID_W = 32;
   localparam int BS_W = 8;
   // Instruction codes
   localparam logic [3:0] INS_EXTEST = 4'h0;
   localparam logic [3:0] INS_INTEST = 4'h1;
   localparam logic [3:0] INS_SAMPLE = 4'h2;
   localparam logic [3:0] INS_IDCODE = 4'he;
   localparam logic [3:0] INS_BYPASS = 4'hf;
   // Captured into the instruction chain, low bits 01 as usual
   localparam logic [3:0] IR_CAPTURE = 4'h1;
   // Identification value, arbitrary
   localparam logic [31:0] ID_VALUE = 32'h0000_0001;

   // Data chain selections
   typedef enum logic [2:0] {
      DSEL_BYPASS = 3'h1,
      DSEL_IDCODE = 3'h2,
      DSEL_BSCAN = 3'h4
   } jtsc_dsel_e;
endpackage : jtsc_pkg

// *** design/jtsc_sync.sv ***
`timescale 1ns/1ps
// Two-flop synchroniser for pin levels
module jtsc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] q_d;

   // Next values
   always_comb begin
      meta_d = d;
      q_d = meta_q;
   end

   // First stage is read only by the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= INIT;
         q <= INIT;
      end else begin
         meta_q <= meta_d;
         q <= q_d;
      end
   end
endmodule : jtsc_sync

// *** design/jtsc_tap.sv ***
`timescale 1ns/1ps
module jtsc_tap
   import jtsc_pkg::*;
#(
   parameter int BSW = BS_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic trst_n,
   output logic tdo_o,
   output logic tdo_oe,
   output logic [BSW-1:0] bscan_out,
   input wire logic [BSW-1:0] bscan_in,
   output logic [IR_W-1:0] ir_active,
   output logic [15:0] tap_state
);
   logic tck_s;
   logic tms_s;
   logic tdi_s;
   logic trst_s;
   logic tck_q;
   logic tck_d;
   logic rise;
   logic fall;
   jtsc_state_e st_q;
   jtsc_state_e st_d;
   logic [IR_W-1:0] irs_q;
   logic [IR_W-1:0] irs_d;
   logic [IR_W-1:0] irp_q;
   logic [IR_W-1:0] irp_d;
   logic byp_q;
   logic byp_d;
   logic [ID_W-1:0] ids_q;
   logic [ID_W-1:0] ids_d;
   logic [BSW-1:0] bss_q;
   logic [BSW-1:0] bss_d;
   logic [BSW-1:0] bsp_q;
   logic [BSW-1:0] bsp_d;
   logic tdo_q;
   logic tdo_d;
   logic oe_q;
   logic oe_d;
   jtsc_dsel_e dsel;
   logic hold_dr;
   logic ser_bit;

   // Pins come from outside; test clock is oversampled, not used as a clock
   jtsc_sync #(.W(4), .INIT(4'hf)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({tck, tms, tdi, trst_n}),
      .q({tck_s, tms_s, tdi_s, trst_s})
   );

   // Edge finder; with no edges only test reset or the reset state changes anything below
   always_comb begin
      tck_d = tck_s;
      rise = tck_s & ~tck_q;
      fall = ~tck_s & tck_q;
   end

   // Unknown codes fall to BYPASS, so a path TDI to TDO exists for every code but EXTEST and INTEST
   function automatic jtsc_dsel_e dec_sel(input logic [IR_W-1:0] ir);
      unique case (ir)
         INS_IDCODE: dec_sel = DSEL_IDCODE;
         INS_SAMPLE, INS_EXTEST, INS_INTEST: dec_sel = DSEL_BSCAN;
         default: dec_sel = DSEL_BYPASS;
      endcase
   endfunction : dec_sel

   // Standard next-state table
   function automatic jtsc_state_e nxt(input jtsc_state_e s, input logic m);
      unique case (s)
         ST_RESET: nxt = m ? ST_RESET : ST_IDLE;
         ST_IDLE: nxt = m ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: nxt = m ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: nxt = m ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: nxt = m ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: nxt = m ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: nxt = m ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: nxt = m ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: nxt = m ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: nxt = m ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR: nxt = m ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: nxt = m ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: nxt = m ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: nxt = m ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: nxt = m ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: nxt = m ? ST_SEL_DR : ST_IDLE;
         default: nxt = ST_RESET;
      endcase
   endfunction : nxt

   // Chain selection from held instruction
   always_comb begin
      dsel = dec_sel(irp_q);
      hold_dr = (irp_q == INS_EXTEST) || (irp_q == INS_INTEST);
   end

   // State machine; five high TMS reach reset by the table itself
   always_comb begin
      st_d = st_q;
      if (!trst_s) begin
         st_d = ST_RESET;
      end else if (rise) begin
         st_d = nxt(st_q, tms_s);
      end
   end

   // Instruction chain
   always_comb begin
      irs_d = irs_q;
      irp_d = irp_q;
      if (!trst_s || st_q == ST_RESET) begin
         irp_d = INS_IDCODE;
      end else if (rise) begin
         unique case (st_q)
            ST_CAP_IR: irs_d = IR_CAPTURE;
            ST_SH_IR: irs_d = {tdi_s, irs_q[IR_W-1:1]};
            ST_UPD_IR: irp_d = irs_q;
            default: irs_d = irs_q;
         endcase
      end
   end

   // Data chains; capture, shift and update gated by state and instruction
   always_comb begin
      byp_d = byp_q;
      ids_d = ids_q;
      bss_d = bss_q;
      bsp_d = bsp_q;
      if (rise && !hold_dr) begin
         unique case (st_q)
            ST_CAP_DR: begin
               byp_d = 1'b0;
               if (dsel == DSEL_IDCODE) ids_d = ID_VALUE;
               if (dsel == DSEL_BSCAN) bss_d = bscan_in;
            end
            ST_SH_DR: begin
               unique case (dsel)
                  DSEL_IDCODE: ids_d = {tdi_s, ids_q[ID_W-1:1]};
                  DSEL_BSCAN: bss_d = {tdi_s, bss_q[BSW-1:1]};
                  default: byp_d = tdi_s;
               endcase
            end
            ST_UPD_DR: begin
               if (dsel == DSEL_BSCAN) bsp_d = bss_q;
            end
            default: byp_d = byp_q;
         endcase
      end
   end

   // Serial out bit for the chain being accessed
   always_comb begin
      unique case (dsel)
         DSEL_IDCODE: ser_bit = ids_q[0];
         DSEL_BSCAN: ser_bit = bss_q[0];
         default: ser_bit = byp_q;
      endcase
      if (st_q == ST_SH_IR) ser_bit = irs_q[0];
   end

   // Output changes on falling edge or test reset, released outside shift states
   always_comb begin
      tdo_d = tdo_q;
      oe_d = oe_q;
      if (!trst_s) begin
         oe_d = 1'b0;
      end else if (fall) begin
         tdo_d = ser_bit;
         oe_d = (st_q == ST_SH_IR) || (st_q == ST_SH_DR && !hold_dr);
      end
   end

   // All state registers; chip reset lands in Test-Logic-Reset too
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tck_q <= 1'b1;
         st_q <= ST_RESET;
         irs_q <= '0;
         irp_q <= INS_IDCODE;
         byp_q <= 1'b0;
         ids_q <= '0;
         bss_q <= '0;
         bsp_q <= '0;
         tdo_q <= 1'b1;
         oe_q <= 1'b0;
      end else begin
         tck_q <= tck_d;
         st_q <= st_d;
         irs_q <= irs_d;
         irp_q <= irp_d;
         byp_q <= byp_d;
         ids_q <= ids_d;
         bss_q <= bss_d;
         bsp_q <= bsp_d;
         tdo_q <= tdo_d;
         oe_q <= oe_d;
      end
   end

   assign tdo_o = tdo_q;
   assign tdo_oe = oe_q;
   assign bscan_out = bsp_q;
   assign ir_active = irp_q;
   assign tap_state = st_q;
endmodule : jtsc_tap

// *** verif/jtsc_tap_props.sv ***
`timescale 1ns/1ps
// Port-level watch on the TAP block
module jtsc_tap_props
   import jtsc_pkg::*;
#(
   parameter int BSW = BS_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic trst_n,
   input wire logic tdo_o,
   input wire logic tdo_oe,
   input wire logic [BSW-1:0] bscan_out,
   input wire logic [BSW-1:0] bscan_in,
   input wire logic [IR_W-1:0] ir_active,
   input wire logic [15:0] tap_state
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Low long enough to clear the two-flop synchroniser
   sequence s_trst_low;
      !trst_n [*4];
   endsequence
   // Pin quiet long enough for the edge detector to settle
   sequence s_tck_still;
      ($stable(tck) && trst_n) [*6];
   endsequence
   a_rst_state: assert property ($rose(rst_n) |->
      tap_state == ST_RESET && !tdo_oe)
      else $error("chip reset did not leave reset state");
   a_trst_hold: assert property (s_trst_low |->
      tap_state == ST_RESET && ir_active == INS_IDCODE)
      else $error("test reset not holding reset state");
   a_state_onehot: assert property ($onehot(tap_state))
      else $error("state code not one-hot");
   a_still_hold: assert property (s_tck_still |->
      $stable(tap_state) && $stable(ir_active))
      else $error("state moved without test clock");
   a_oe_shift: assert property (tdo_oe |->
      (tap_state & 16'h1830) != 16'h0 || tap_state == ST_EX1_DR)
      else $error("data out driven outside shift");
   a_ext_quiet: assert property (tdo_oe && tap_state == ST_SH_DR |->
      ir_active > 4'h1)
      else $error("data chain shifted under extest");
   a_bscan_upd: assert property ($changed(bscan_out) |->
      ir_active == INS_SAMPLE)
      else $error("boundary register changed outside sample");
   // Instruction loads as the state leaves update, so the state before counts too
   a_ir_upd: assert property ($changed(ir_active) |->
      (($past(tap_state) | tap_state) & 16'h8001) != 16'h0)
      else $error("instruction changed outside update or reset");
   a_tdo_fall: assert property (($changed(tdo_o) || $changed(tdo_oe)) && trst_n
      && $past(trst_n, 3) |-> !$past(tck, 2))
      else $error("data out moved away from falling edge");
endmodule : jtsc_tap_props

bind jtsc_tap jtsc_tap_props #(.BSW(BSW)) jtsc_tap_props_i (.clk(clk), .rst_n(rst_n), .tck(tck),
   .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .bscan_out(bscan_out),
   .bscan_in(bscan_in), .ir_active(ir_active), .tap_state(tap_state));

// *** verif/jtsc_tester.sv ***
`timescale 1ns/1ps
// Probe end: test clock stands high between scans
module jtsc_tester (
   input wire logic clk,
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo_o,
   input wire logic tdo_oe
);
   logic tdo_w;
   // Released line rests at the pull-up level
   assign tdo_w = tdo_oe ? tdo_o : 1'b1;
   initial begin
      tck = 1'b1;
      tms = 1'b1;
      tdi = 1'b1;
   end
   // One 200 ns test clock; entered on a falling clk edge
   task automatic bit_io(input logic m, input logic d, output logic q);
      tck = 1'b0;
      tms = m;
      tdi = d;
      repeat (4) @(negedge clk);
      q = tdo_w; // Taken late, after the fall has settled
      tck = 1'b1;
      repeat (4) @(negedge clk);
   endtask : bit_io
   // Stop the test clock low; levels change with the fall as usual
   task automatic hold_low(input logic m, input logic d);
      tck = 1'b0;
      tms = m;
      tdi = d;
      repeat (4) @(negedge clk);
   endtask : hold_low
endmodule : jtsc_tester

// *** verif/jtsc_tap_tb.sv ***
`timescale 1ns/1ps
module jtsc_tap_tb;
   import jtsc_pkg::*;
   localparam logic [3:0] CODES [5] = '{INS_SAMPLE, INS_EXTEST, INS_INTEST, INS_IDCODE,
      INS_BYPASS};
   logic clk, rst_n, trst_n, tck, tms, tdi, tdo_o, tdo_oe, q;
   logic [BS_W-1:0] bscan_out, bscan_in, dat, exp_bo;
   logic [IR_W-1:0] ir_active, code;
   logic [15:0] tap_state;
   logic [31:0] rnd;
   int n_fail = 0;
   int check_count = 0;
   jtsc_tap #(.BSW(BS_W)) jtsc_tap_i (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
      .trst_n(trst_n), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .bscan_out(bscan_out),
      .bscan_in(bscan_in), .ir_active(ir_active), .tap_state(tap_state));
   jtsc_tester jtsc_tester_i (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o),
      .tdo_oe(tdo_oe));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   // Bit expected on the wire at data shift step i
   function automatic logic exp_dr(input logic [3:0] c, input int i, input logic [7:0] d,
      input logic [7:0] b);
      case (c)
         INS_EXTEST, INS_INTEST: return 1'b1; // Released, pull-up shows
         INS_IDCODE: return ID_VALUE[i];
         INS_SAMPLE: return b[i];
         default: return (i == 0) ? 1'b0 : d[i-1]; // One-bit bypass delay
      endcase
   endfunction : exp_dr
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Test clocks with no data, mode bits taken low bit first
   task automatic walk(input logic [7:0] m, input int n);
      for (int k = 0; k < n; k++) jtsc_tester_i.bit_io(m[k], 1'b0, q);
   endtask : walk
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : wrap_up
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Whole run is near 1500 clk; this leaves wide margin
   initial begin
      #200000;
      n_fail++;
      wrap_up();
   end
   initial begin
      rst_n = 1'b0;
      trst_n = 1'b1;
      bscan_in = 8'h00;
      exp_bo = 8'h00;
      rnd = 32'h0000e0fd;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      chk(ir_active, INS_IDCODE);
      chk(tap_state, ST_RESET);
      chk(tdo_oe, 1'b0);
      repeat (3) @(negedge clk);
      walk(8'h00, 1);
      // Every implemented code, then two unused ones
      for (int j = 0; j < 7; j++) begin
         rnd = xs(rnd);
         code = (j < 5) ? CODES[j] : 4'h3 + 4'(rnd % 11);
         walk(8'h03, 4);
         for (int i = 0; i < IR_W; i++) begin
            jtsc_tester_i.bit_io(i == IR_W - 1, code[i], q);
            chk(q, IR_CAPTURE[i]);
         end
         walk(8'h01, 2);
         if (j < 5) chk(ir_active, code);
         dat = rnd[7:0];
         bscan_in = rnd[15:8];
         walk(8'h01, 3);
         for (int i = 0; i < BS_W; i++) begin
            jtsc_tester_i.bit_io(i == BS_W - 1, dat[i], q);
            chk(q, exp_dr(code, i, dat, bscan_in));
         end
         walk(8'h01, 2);
         if (code == INS_SAMPLE) exp_bo = dat;
         chk(bscan_out, exp_bo);
      end
      walk(8'h01, 3);
      walk(8'h1f, 5);
      chk(tap_state, ST_RESET);
      chk(ir_active, INS_IDCODE);
      walk(8'h06, 5);
      repeat (40) @(negedge clk);
      chk(tap_state, ST_SH_IR);
      // Clock stopped low in shift: output must be driven, state kept
      jtsc_tester_i.hold_low(1'b1, 1'b1);
      chk(tdo_oe, 1'b1);
      chk(tdo_o, IR_CAPTURE[0]);
      repeat (40) @(negedge clk);
      chk(tap_state, ST_SH_IR);
      trst_n = 1'b0;
      repeat (4) @(negedge clk);
      chk(tap_state, ST_RESET);
      chk(tdo_oe, 1'b0);
      trst_n = 1'b1;
      jtsc_tester_i.bit_io(1'b1, 1'b1, q);
      chk(tap_state, ST_RESET);
      chk(ir_active, INS_IDCODE);
      wrap_up();
   end
endmodule : jtsc_tap_tb
